/* File: rdf_consts.vh */
// Constants for the radio data FIFO pair
// Operation
// R1: Two separate 64-byte FIFOs, one for receive data, one for transmit data.
// R2: Host port may only read the receive FIFO and only write the transmit FIFO.
// R3: Receive overflow and transmit underflow are detected and flagged.
// R4: Host must not overfill the transmit FIFO; overfill corrupts its contents. Here such writes are dropped instead.
// R5: Host must not read an empty receive FIFO; such reads return bad data.
// R6: Header status carries receive fill on reads, transmit fill on writes.
// R7: Receive and transmit byte counts are readable as separate status values.
// R8: Host should not empty receive FIFO before the packet's last byte arrives.
// R9: For short packets host should wait for the whole packet before reading.
// R10: For long packets host polls count twice, then reads one byte fewer.
// R11: One 4-bit field sets both FIFO thresholds together.
// R12: Receive threshold is 4(k+1), transmit threshold is 61 minus 4k.
// R13: Threshold signal is high when the count is at or above threshold.
// R14: Each threshold signal can be routed to the general output pins.
// R15: Entering sleep empties both FIFOs and clears their counts.
// R16: Byte counts are 7 bits wide to hold 0 through 64.
// R17: Overflow and underflow flags stay set until a flush of that FIFO.
`ifndef RDF_CONSTS_VH
`define RDF_CONSTS_VH
`define RDF_DEPTH 7'h40
`define RDF_CNT_W 7
`define RDF_PTR_W 6
`define RDF_RX_THR_STEP 7'h04
`define RDF_TX_THR_BASE 7'h3D
`define RDF_SEL_RX_THR 2'h0
`define RDF_SEL_TX_THR 2'h1
`define RDF_SEL_RX_OVF 2'h2
`define RDF_SEL_TX_UNF 2'h3
`endif

/* File: rdf_fifo.v */
// One 64-byte FIFO with fill count and sticky error flags
`include "rdf_consts.vh"
module rdf_fifo (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Flush
    input wire flush_in,
    // Push side
    input wire push_in,
    input wire [7:0] push_data_in,
    // Pop side
    input wire pop_in,
    output wire [7:0] pop_data_out,
    // Status
    output reg [`RDF_CNT_W-1:0] count_out,
    output reg overflow_out,
    output reg underflow_out
);
    reg [7:0] mem [0:63]; // R1
    reg [`RDF_PTR_W-1:0] wr_q;
    reg [`RDF_PTR_W-1:0] rd_q;
    wire full = (count_out == `RDF_DEPTH);
    wire empty = (count_out == 7'h00);
    wire do_push = push_in && !full;
    wire do_pop = pop_in && !empty;

    // Storage write; dropped when full so old bytes survive
    always @(posedge clk_in) begin
        if (do_push) begin
            mem[wr_q] <= push_data_in;
        end
    end
    assign pop_data_out = mem[rd_q];

    // Pointers, count and sticky flags
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_q <= 6'h00;
            rd_q <= 6'h00;
            count_out <= 7'h00;
            overflow_out <= 1'b0;
            underflow_out <= 1'b0;
        end else if (flush_in) begin
            wr_q <= 6'h00; // R15
            rd_q <= 6'h00;
            count_out <= 7'h00;
            // A same-cycle error event survives the flush, so none is lost
            overflow_out <= push_in && full; // R17
            underflow_out <= pop_in && empty; // R3
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 6'h01;
            end
            if (do_pop) begin
                rd_q <= rd_q + 6'h01;
            end
            // Simultaneous push and pop keeps the count except when full (pop only) or empty (push only); no duplicate byte here
            if (do_push && !do_pop) begin
                count_out <= count_out + 7'h01; // R16
            end else if (do_pop && !do_push) begin
                count_out <= count_out - 7'h01;
            end
            if (push_in && full) begin
                overflow_out <= 1'b1; // R3
            end
            if (pop_in && empty) begin
                underflow_out <= 1'b1; // R3
            end
        end
    end
endmodule

/* File: rdf_top.v */
// Receive/transmit data FIFO pair with thresholds and status
`include "rdf_consts.vh"
module rdf_top (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Power state: rising edge of sleep flushes both FIFOs
    input wire sleep_in,
    // Host flush commands (one-cycle pulses, same clock)
    input wire rx_flush_in,
    input wire tx_flush_in,
    // Host side: read receive FIFO, write transmit FIFO
    input wire host_rd_in,
    output reg [7:0] host_rd_data_out,
    input wire host_wr_in,
    input wire [7:0] host_wr_data_in,
    // Access header phase and direction (1 = read)
    input wire header_active_in,
    input wire header_is_read_in,
    output reg [`RDF_CNT_W-1:0] header_fill_out,
    // Modem side, clocked by the link clock pin
    input wire link_clk_in,
    input wire modem_rx_push_in,
    input wire [7:0] modem_rx_data_in,
    input wire modem_tx_pop_in,
    output reg [7:0] modem_tx_data_out,
    // Configuration
    input wire [3:0] threshold_select_in,
    input wire [1:0] gpo_select_in,
    // Status
    output reg [`RDF_CNT_W-1:0] rx_count_status_out,
    output reg [`RDF_CNT_W-1:0] tx_count_status_out,
    output reg rx_overflow_out,
    output reg tx_underflow_out,
    output reg rx_threshold_out,
    output reg tx_threshold_out,
    output reg general_output_pin_out
);
    // ----------------------------------------
    // Usage limits
    // ----------------------------------------
    // Link clock must run well below a quarter of the core clock
    // Modem strobes must stand across one whole link clock high phase
    // Host writes into a full transmit FIFO are dropped without a flag
    // Host reads of an empty receive FIFO return the stale head byte

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Receive threshold 4(k+1), from 4 to 64
    function [6:0] rx_thr;
        input [3:0] k;
        begin
            rx_thr = ({3'h0, k} + 7'h01) << 2; // R12
        end
    endfunction
    // Transmit threshold 61-4k, from 61 down to 1
    function [6:0] tx_thr;
        input [3:0] k;
        begin
            tx_thr = `RDF_TX_THR_BASE - {1'b0, k, 2'h0}; // R12
        end
    endfunction

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Link clock and strobe stages
    reg [2:0] lclk_q;
    reg [1:0] rxp_s_q;
    reg [1:0] txp_s_q;
    // Receive data stages
    reg [7:0] rxd_s1_q;
    reg [7:0] rxd_s2_q;
    // Sleep pin stages and edge memory
    reg [1:0] slp_s_q;
    reg slp_d_q;

    // Link clock and strobes pass two flops; a third remembers the clock
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lclk_q <= 3'h0;
            rxp_s_q <= 2'h0;
            txp_s_q <= 2'h0;
        end else begin
            lclk_q <= {lclk_q[1:0], link_clk_in};
            rxp_s_q <= {rxp_s_q[0], modem_rx_push_in};
            txp_s_q <= {txp_s_q[0], modem_tx_pop_in};
        end
    end

    // Receive byte stages; the modem holds the byte around its clock edge
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rxd_s1_q <= 8'h00;
            rxd_s2_q <= 8'h00;
        end else begin
            rxd_s1_q <= modem_rx_data_in;
            rxd_s2_q <= rxd_s1_q;
        end
    end

    // Sleep pin stages; reset matches the idle level, so no false edge
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            slp_s_q <= 2'h0;
            slp_d_q <= 1'b0;
        end else begin
            slp_s_q <= {slp_s_q[0], sleep_in};
            slp_d_q <= slp_s_q[1];
        end
    end

    // Rising link clock edge; strobes are held stable across it by the modem
    wire link_rise = lclk_q[1] && !lclk_q[2];
    wire sleep_enter = slp_s_q[1] && !slp_d_q;
    wire rx_push = link_rise && rxp_s_q[1];
    wire tx_pop = link_rise && txp_s_q[1];

    // ----------------------------------------
    // FIFO instances
    // ----------------------------------------
    wire [6:0] rx_cnt;
    wire [6:0] tx_cnt;
    wire [7:0] rx_head;
    wire [7:0] tx_head;
    wire rx_ovf;
    wire tx_unf;
    // Receive FIFO: modem pushes, host only pops
    rdf_fifo u_rx (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .flush_in(rx_flush_in || sleep_enter), // R15
        .push_in(rx_push),
        .push_data_in(rxd_s2_q),
        .pop_in(host_rd_in), // R2
        .pop_data_out(rx_head),
        .count_out(rx_cnt),
        .overflow_out(rx_ovf),
        .underflow_out()
    );
    // Transmit FIFO: host only pushes, modem pops
    rdf_fifo u_tx (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .flush_in(tx_flush_in || sleep_enter), // R15
        .push_in(host_wr_in), // R2
        .push_data_in(host_wr_data_in),
        .pop_in(tx_pop),
        .pop_data_out(tx_head),
        .count_out(tx_cnt),
        .overflow_out(),
        .underflow_out(tx_unf)
    );

    // ----------------------------------------
    // Thresholds and output pin mux
    // ----------------------------------------
    wire rx_thr_hit = (rx_cnt >= rx_thr(threshold_select_in)); // R11 R13
    wire tx_thr_hit = (tx_cnt >= tx_thr(threshold_select_in)); // R11 R13
    reg gpo_d;
    // Selected source for the general output pin
    always @* begin
        case (gpo_select_in)
            `RDF_SEL_RX_THR: gpo_d = rx_thr_hit; // R14
            `RDF_SEL_TX_THR: gpo_d = tx_thr_hit; // R14
            `RDF_SEL_RX_OVF: gpo_d = rx_ovf;
            `RDF_SEL_TX_UNF: gpo_d = tx_unf;
            default: gpo_d = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    // Data bytes for host and modem; each holds until the next pop
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            host_rd_data_out <= 8'h00;
            modem_tx_data_out <= 8'h00;
        end else begin
            if (host_rd_in) begin
                host_rd_data_out <= rx_head;
            end
            if (tx_pop) begin
                modem_tx_data_out <= tx_head;
            end
        end
    end

    // Header fill holds its last value while no header is shifting
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            header_fill_out <= 7'h00;
        end else begin
            if (header_active_in) begin
                header_fill_out <= header_is_read_in ? rx_cnt : tx_cnt; // R6
            end
        end
    end

    // Counts and sticky flags; status lags the counts by one cycle
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_count_status_out <= 7'h00;
            tx_count_status_out <= 7'h00;
            rx_overflow_out <= 1'b0;
            tx_underflow_out <= 1'b0;
        end else begin
            rx_count_status_out <= rx_cnt; // R7
            tx_count_status_out <= tx_cnt; // R7
            rx_overflow_out <= rx_ovf; // R3
            tx_underflow_out <= tx_unf; // R3
        end
    end

    // Threshold levels and the pin, flopped so the pin cannot glitch
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_threshold_out <= 1'b0;
            tx_threshold_out <= 1'b0;
            general_output_pin_out <= 1'b0;
        end else begin
            rx_threshold_out <= rx_thr_hit; // R13
            tx_threshold_out <= tx_thr_hit; // R13
            general_output_pin_out <= gpo_d; // R14
        end
    end
endmodule

/* File: rdf_props.sv */
// Concurrent checks on the FIFO pair status ports
`include "rdf_consts.vh"
module rdf_props (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Controls
    input wire sleep_in,
    input wire rx_flush_in,
    input wire tx_flush_in,
    input wire header_active_in,
    input wire header_is_read_in,
    input wire [3:0] threshold_select_in,
    input wire [1:0] gpo_select_in,
    // Status outputs
    input wire [6:0] header_fill_out,
    input wire [6:0] rx_count_status_out,
    input wire [6:0] tx_count_status_out,
    input wire rx_overflow_out,
    input wire tx_underflow_out,
    input wire rx_threshold_out,
    input wire tx_threshold_out,
    input wire general_output_pin_out
);
    // Threshold base and output pin sources
    wire [6:0] k4 = {1'h0, threshold_select_in, 2'h0};
    wire [3:0] srcs = {tx_underflow_out, rx_overflow_out, tx_threshold_out, rx_threshold_out};
    reg [3:0] quiet_q;
    // Cycles since a flush or sleep; a flag may only drop shortly after one
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            quiet_q <= 4'h0;
        end else if (sleep_in || rx_flush_in || tx_flush_in) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Settled setting and count, so a registered lag is not mistaken for a fault
    sequence rx_calm;
        ($stable(threshold_select_in) && $stable(rx_count_status_out)) [*2];
    endsequence
    sequence tx_calm;
        ($stable(threshold_select_in) && $stable(tx_count_status_out)) [*2];
    endsequence
    sequence sleep_edge;
        !sleep_in ##1 sleep_in;
    endsequence
    a_rx_thr_level: assert property (rx_calm |->
        rx_threshold_out == (rx_count_status_out >= k4 + `RDF_RX_THR_STEP)) else $error("rx thr");
    a_tx_thr_level: assert property (tx_calm |->
        tx_threshold_out == (tx_count_status_out >= `RDF_TX_THR_BASE - k4)) else $error("tx thr");
    a_count_range: assert property (rx_count_status_out <= `RDF_DEPTH
        && tx_count_status_out <= `RDF_DEPTH) else $error("count range");
    a_hdr_read_fill: assert property ($past(header_active_in) && $past(header_is_read_in)
        |-> header_fill_out == rx_count_status_out) else $error("header read fill");
    a_hdr_write_fill: assert property ($past(header_active_in) && !$past(header_is_read_in)
        |-> header_fill_out == tx_count_status_out) else $error("header write fill");
    a_ovf_at_full: assert property ($rose(rx_overflow_out)
        |-> rx_count_status_out == `RDF_DEPTH) else $error("overflow not at full");
    a_unf_at_empty: assert property ($rose(tx_underflow_out)
        |-> tx_count_status_out == 7'h00) else $error("underflow not at empty");
    a_ovf_sticky: assert property ($fell(rx_overflow_out) |-> quiet_q < 4'h6)
        else $error("overflow dropped");
    a_unf_sticky: assert property ($fell(tx_underflow_out) |-> quiet_q < 4'h6)
        else $error("underflow dropped");
    a_sleep_empties: assert property (sleep_edge |-> ##[1:10]
        (rx_count_status_out == 7'h00 && tx_count_status_out == 7'h00)) else $error("sleep");
    a_gpo_route: assert property ($stable(gpo_select_in) && $stable(srcs)
        |-> general_output_pin_out == srcs[gpo_select_in]) else $error("pin source");
endmodule
bind rdf_top rdf_props chk_u (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sleep_in(sleep_in),
    .rx_flush_in(rx_flush_in),
    .tx_flush_in(tx_flush_in),
    .header_active_in(header_active_in),
    .header_is_read_in(header_is_read_in),
    .threshold_select_in(threshold_select_in),
    .gpo_select_in(gpo_select_in),
    .header_fill_out(header_fill_out),
    .rx_count_status_out(rx_count_status_out),
    .tx_count_status_out(tx_count_status_out),
    .rx_overflow_out(rx_overflow_out),
    .tx_underflow_out(tx_underflow_out),
    .rx_threshold_out(rx_threshold_out),
    .tx_threshold_out(tx_threshold_out),
    .general_output_pin_out(general_output_pin_out)
);

/* File: rdf_modem_model.sv */
// Behavioural modem that clocks bytes in and out of the FIFO pair
module rdf_modem_model (
    // Link clock and strobes
    output logic link_clk_out,
    output logic push_out,
    output logic pop_out,
    // Bytes towards and from the FIFO pair
    output logic [7:0] data_out,
    input wire logic [7:0] tx_data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Link clock rests low between frames
    initial begin
        link_clk_out = 1'h0;
        push_out = 1'h0;
        pop_out = 1'h0;
        data_out = 8'hA5;
    end
    task automatic cyc();
        #62.5 link_clk_out = 1'h1;
        #62.5 link_clk_out = 1'h0;
    endtask
    // Released data shows the inverse so stale bytes cannot pass
    task automatic push_byte(input logic [7:0] d);
        push_out = 1'h1;
        data_out = d;
        cyc();
        push_out = 1'h0;
        data_out = ~d;
    endtask
    task automatic pop_byte(output logic [7:0] d);
        pop_out = 1'h1;
        cyc();
        pop_out = 1'h0;
        #62.5 d = tx_data_in;
    endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the radio data FIFO pair
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'h0, rst_n_in = 1'h0, sleep_in = 1'h0, rx_flush_in = 1'h0;
    logic tx_flush_in = 1'h0, host_rd_in = 1'h0, host_wr_in = 1'h0;
    logic header_active_in = 1'h0, header_is_read_in = 1'h0;
    logic [7:0] host_wr_data_in = 8'h00, host_rd_data_out, modem_tx_data_out, modem_rx_data_in, b;
    logic [3:0] threshold_select_in = 4'h0;
    logic [1:0] gpo_select_in = 2'h0;
    logic [6:0] header_fill_out, rx_count_status_out, tx_count_status_out;
    logic link_clk_in, modem_rx_push_in, modem_tx_pop_in, rx_overflow_out, tx_underflow_out;
    logic rx_threshold_out, tx_threshold_out, general_output_pin_out;
    logic [7:0] txq[$], rxq[$];
    int mismatches = 0, comparisons = 0;
    rdf_top dut_u (.*);
    rdf_modem_model modem_u (.link_clk_out(link_clk_in), .push_out(modem_rx_push_in),
        .pop_out(modem_tx_pop_in), .data_out(modem_rx_data_in), .tx_data_in(modem_tx_data_out));
    // System clock
    always #5 clk_in = ~clk_in;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected flags, pin sources in select order
    function automatic logic [3:0] exp_src(logic [6:0] rn, tn, logic [1:0] f, int j);
        return {f, tn >= 61 - 4 * j, rn >= 4 * (j + 1)};
    endfunction
    task automatic gap(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // One-cycle flush of the receive or the transmit side
    task automatic flush(input logic rx_side);
        @(posedge clk_in) rx_flush_in <= rx_side;
        tx_flush_in <= !rx_side;
        @(posedge clk_in) rx_flush_in <= 1'h0;
        tx_flush_in <= 1'h0;
    endtask
    // Long packet drain: poll until two counts agree, keep one byte back until the count equals the bytes left
    task automatic rd_long(input int left);
        int n;
        int m;
        while (left > 0) begin
            n = -1;
            do begin
                m = n;
                gap(2);
                n = rx_count_status_out;
            end while (n != m);
            if (n == left) begin
                hrd(left);
                left = 0;
            end else if (n > 1) begin
                hrd(n - 1);
                left -= n - 1;
            end
        end
    endtask
    task automatic hwr(input int n);
        repeat (n) begin
            @(posedge clk_in) host_wr_in <= 1'h1;
            host_wr_data_in <= 8'($urandom);
            #1 if (txq.size() < 64) txq.push_back(host_wr_data_in);
            @(posedge clk_in) host_wr_in <= 1'h0;
        end
    endtask
    task automatic hrd(input int n);
        repeat (n) begin
            @(posedge clk_in) host_rd_in <= 1'h1;
            @(posedge clk_in) host_rd_in <= 1'h0;
            #1 chk(host_rd_data_out, rxq.pop_front());
        end
    endtask
    task automatic mpop(input int n);
        repeat (n) begin
            modem_u.pop_byte(b);
            chk(b, txq.pop_front());
        end
    endtask
    task automatic mpush(input int n);
        repeat (n) begin
            b = 8'($urandom);
            if (rxq.size() < 64) rxq.push_back(b);
            modem_u.push_byte(b);
        end
    endtask
    task automatic sweep(input logic [6:0] rn, tn, input logic [1:0] f);
        logic [3:0] e;
        for (int j = 0; j < 16; j++) begin
            @(posedge clk_in) threshold_select_in <= 4'(j);
            gpo_select_in <= 2'(j);
            gap(4);
            e = exp_src(rn, tn, f, j);
            chk(rx_threshold_out, e[0]);
            chk(tx_threshold_out, e[1]);
            chk(general_output_pin_out, e[j % 4]);
        end
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #400000;
        mismatches++;
        summarize();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hAEA485C3));
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'h1;
        hwr(64);
        gap(3);
        chk(tx_count_status_out, 8'h40);
        mpop(4);
        mpush(65);
        gap(3);
        chk(rx_overflow_out, 8'h01);
        @(posedge clk_in) header_active_in <= 1'h1;
        header_is_read_in <= 1'h1;
        gap(3);
        chk(header_fill_out, 8'h40);
        @(posedge clk_in) header_is_read_in <= 1'h0;
        gap(3);
        chk(header_fill_out, 8'h3C);
        @(posedge clk_in) header_active_in <= 1'h0;
        hrd(1);
        sweep(7'h3F, 7'h3C, 2'h1);
        mpop(60);
        modem_u.pop_byte(b);
        gap(3);
        chk(tx_underflow_out, 8'h01);
        gap(20);
        chk(tx_underflow_out, 8'h01);
        flush(1'h0);
        gap(3);
        chk(tx_underflow_out, 8'h00);
        hrd(63);
        gap(2);
        chk(rx_count_status_out, 8'h00);
        flush(1'h1);
        gap(3);
        chk(rx_overflow_out, 8'h00);
        fork
            mpush(40);
            rd_long(40);
        join
        gap(3);
        chk(rx_count_status_out, 8'h00);
        hwr(5);
        mpush(3);
        hrd(2);
        gap(3);
        chk(tx_count_status_out, 8'h05);
        chk(rx_count_status_out, 8'h01);
        @(posedge clk_in) sleep_in <= 1'h1;
        gap(10);
        chk(rx_count_status_out, 8'h00);
        chk(tx_count_status_out, 8'h00);
        @(posedge clk_in) sleep_in <= 1'h0;
        gap(2);
        summarize();
    end
endmodule
